// ===== hw/ptx_map.svh
// Register offsets, field positions and reset values of the pattern test engine.
// Assumes a 32-bit register bus with byte addresses.
`ifndef PTX_MAP_SVH
`define PTX_MAP_SVH

`define PTX_ADDR_W 8
`define PTX_OFS_CTRL 8'h00
`define PTX_OFS_STATUS 8'h04
`define PTX_OFS_END_LO 8'h08
`define PTX_OFS_END_HI 8'h0c
`define PTX_OFS_ADDR_LO 8'h10
`define PTX_OFS_ADDR_HI 8'h14
`define PTX_OFS_COUNT_LO 8'h18
`define PTX_OFS_COUNT_HI 8'h1c

`define PTX_CTRL_START_BIT 0
`define PTX_CTRL_DIR_BIT 1
`define PTX_CTRL_VERIFY_BIT 2
`define PTX_CTRL_PATT_LSB 4
`define PTX_CTRL_PATT_MSB 6
`define PTX_STAT_BUSY_BIT 0
`define PTX_STAT_WRITE_BIT 1
`define PTX_STAT_READ_BIT 2
`define PTX_STAT_FAIL_BIT 3

`define PTX_END_RST 48'h00_0000_0000
`define PTX_ADDR_RST 48'h00_0000_0000
`define PTX_RESP_OKAY 2'h0
`define PTX_RESP_SLVERR 2'h2
`define PTX_LAST_WORD_IDX 4'hf
`define PTX_DW_PER_WORD 52'h0_0000_0000_0008

`endif

// ===== hw/ptx_pkg.sv
// Types shared by the pattern test engine files.
// Assumes the constants of ptx_map.svh are included where numbers are needed.
package ptx_pkg;

	typedef enum logic [2:0] {
		PTX_PATT_ZERO = 3'h0,
		PTX_PATT_ONE = 3'h1,
		PTX_PATT_INC = 3'h2,
		PTX_PATT_DEC = 3'h3,
		PTX_PATT_LFSR = 3'h4
	} ptx_patt_t;

	typedef enum logic [2:0] {
		PTX_ST_IDLE = 3'b001,
		PTX_ST_WRITE = 3'b010,
		PTX_ST_READ = 3'b100
	} ptx_state_t;

	typedef struct packed {
		ptx_patt_t patt;
		logic verify;
		logic dir_read;
	} ptx_cfg_t;

endpackage

// ===== hw/ptx_lfsr_half.sv
// One half of the wide LFSR source: four consecutive 32-bit values per cycle.
// Assumes the caller loads a nonzero seed before advancing.
`timescale 1ns/1ps
`default_nettype none

module ptx_lfsr_half (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic adv,
	input wire logic [31:0] seed,
	output logic [127:0] words
);

	// One shift with feedback from powers 31, 21, 1 and 0.
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Look-ahead expansion of one value into four consecutive values.
	function automatic logic [127:0] expand(input logic [31:0] v);
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		a = lfsr_step(v);
		b = lfsr_step(a);
		c = lfsr_step(b);
		expand = {c, b, a, v};
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			words <= 128'h0;
		end else if (load) begin
			words <= expand(seed);
		end else if (adv) begin
			words <= expand(lfsr_step(words[127:96]));
		end
	end

endmodule

`default_nettype wire

// ===== hw/ptx_engine.sv
// Pattern test engine: streams patterned words into the outbound buffer and checks
// words drained from the inbound buffer. Registers sit on an AXI4-Lite slave.
// Assumes show-ahead buffers on the same clock: inbound data is valid while not empty.
// Contract
// - Outbound write strobe high only while write active and almost-full is low; the registered strobe can stay high in the clock where almost-full rises.
// - Almost-full during a write pauses the strobe; it resumes when cleared.
// - In a read test, read strobe rises whenever inbound empty is low.
// - Word count equal to end limit ends the transfer and drops the strobe.
// - Selector picks zeros, ones, incrementing, decrementing or LFSR data.
// - Zero and one patterns fill every bit, no header inserted.
// - Other patterns: 64-bit header in dwords 0-1, data in dwords 2-127.
// - Header from block address counter; loads start value, steps per block.
// - Incrementing data from a 52-bit counter, one per dword.
// - Decrementing data is the inverse of incrementing data.
// - LFSR feedback uses powers 31, 21, 1 and 0.
// - 256-bit LFSR word is two 128-bit halves with different seeds.
// - Each half yields four consecutive 32-bit LFSR values per cycle.
// - Seeds combine the 32-bit block address and its inverse.
// - Fail flag rises when verify is enabled and a read word differs from the expected word.
// - Start gives a one-clock pulse; write active rises the next clock.
// - Write strobe enables the word counter.
// - At end count, write active and write strobe drop in the same cycle.
// - Read strobe depends only on empty and the direction bit, not on start or count.
// - Each read strobe advances word counter and pattern counters; address counter steps per block.
// - Software registers hold end size, direction, verify enable and pattern.
// - Engine and storage logic share one user clock.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ptx_map.svh"

module ptx_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`PTX_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PTX_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic outbound_almost_full_flag,
	output logic outbound_write_strobe,
	output logic [255:0] outbound_data,
	input wire logic inbound_empty_flag,
	output logic inbound_read_strobe,
	input wire logic [255:0] inbound_data,
	output logic write_active_flag,
	output logic fail_flag
);

	ptx_pkg::ptx_cfg_t cfg;
	ptx_pkg::ptx_state_t state;
	logic [47:0] end_count_limit;
	logic [47:0] start_address;
	logic [47:0] transfer_word_count;
	logic [47:0] block_address;
	logic [3:0] word_idx;
	logic [51:0] inc_count;
	logic write_start_pulse;
	logic read_start_pulse;
	logic write_strobe_reg;
	logic advance;
	logic last_word;
	logic block_end;
	logic next_write_strobe;
	logic [255:0] pattern_word;
	logic [255:0] lfsr_word;
	logic [47:0] next_block_address;
	logic aw_held;
	logic w_held;
	logic [`PTX_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic start_cmd;
	// Merges a write word into a register word lane by lane.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction
	// Seed of one LFSR half from a block address and its inverse.
	function automatic logic [31:0] seed_of(input logic [47:0] a, input logic upper);
		logic [31:0] block_address_value;
		logic [31:0] block_address_inverted;
		block_address_value = a[31:0];
		block_address_inverted = ~a[31:0];
		if (upper) begin
			seed_of = {block_address_inverted[15:0], block_address_value[15:0]};
		end else begin
			seed_of = {block_address_value[31:16], block_address_inverted[31:16]};
		end
	endfunction
	// The register bus takes address and data in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
	end
	logic [`PTX_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_mapped;
	assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data = w_held ? w_data : s_axi_wdata;
	assign wr_strb = w_held ? w_strb : s_axi_wstrb;
	assign wr_mapped = (wr_addr == `PTX_OFS_CTRL) || (wr_addr == `PTX_OFS_END_LO) ||
		(wr_addr == `PTX_OFS_END_HI) || (wr_addr == `PTX_OFS_ADDR_LO) ||
		(wr_addr == `PTX_OFS_ADDR_HI);
	assign start_cmd = do_write && (wr_addr == `PTX_OFS_CTRL) && wr_strb[0] &&
		wr_data[`PTX_CTRL_START_BIT] && (state == ptx_pkg::PTX_ST_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PTX_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? `PTX_RESP_OKAY : `PTX_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// Settings registers; the configuration is frozen while a test runs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= '{patt: ptx_pkg::PTX_PATT_ZERO, verify: 1'b0, dir_read: 1'b0};
			end_count_limit <= `PTX_END_RST;
			start_address <= `PTX_ADDR_RST;
		end else if (do_write && state == ptx_pkg::PTX_ST_IDLE) begin
			if (wr_addr == `PTX_OFS_CTRL) begin
				if (wr_strb[0]) begin
					cfg.dir_read <= wr_data[`PTX_CTRL_DIR_BIT];
					cfg.verify <= wr_data[`PTX_CTRL_VERIFY_BIT];
					cfg.patt <= ptx_pkg::ptx_patt_t'(
						wr_data[`PTX_CTRL_PATT_MSB:`PTX_CTRL_PATT_LSB]);
				end
			end else if (wr_addr == `PTX_OFS_END_LO) begin
				end_count_limit[31:0] <= merge(end_count_limit[31:0], wr_data, wr_strb);
			end else if (wr_addr == `PTX_OFS_END_HI) begin
				end_count_limit[47:32] <= 16'(merge({16'h0000, end_count_limit[47:32]},
					wr_data, wr_strb));
			end else if (wr_addr == `PTX_OFS_ADDR_LO) begin
				start_address[31:0] <= merge(start_address[31:0], wr_data, wr_strb);
			end else if (wr_addr == `PTX_OFS_ADDR_HI) begin
				start_address[47:32] <= 16'(merge({16'h0000, start_address[47:32]},
					wr_data, wr_strb));
			end
		end
	end
	// Register read decode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PTX_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `PTX_RESP_OKAY;
			if (s_axi_araddr == `PTX_OFS_CTRL) begin
				s_axi_rdata <= {25'h0, cfg.patt, 1'b0, cfg.verify, cfg.dir_read, 1'b0};
			end else if (s_axi_araddr == `PTX_OFS_STATUS) begin
				s_axi_rdata <= {28'h0, fail_flag, state == ptx_pkg::PTX_ST_READ,
					write_active_flag, state != ptx_pkg::PTX_ST_IDLE};
			end else if (s_axi_araddr == `PTX_OFS_END_LO) begin
				s_axi_rdata <= end_count_limit[31:0];
			end else if (s_axi_araddr == `PTX_OFS_END_HI) begin
				s_axi_rdata <= {16'h0000, end_count_limit[47:32]};
			end else if (s_axi_araddr == `PTX_OFS_ADDR_LO) begin
				s_axi_rdata <= start_address[31:0];
			end else if (s_axi_araddr == `PTX_OFS_ADDR_HI) begin
				s_axi_rdata <= {16'h0000, start_address[47:32]};
			end else if (s_axi_araddr == `PTX_OFS_COUNT_LO) begin
				s_axi_rdata <= transfer_word_count[31:0];
			end else if (s_axi_araddr == `PTX_OFS_COUNT_HI) begin
				s_axi_rdata <= {16'h0000, transfer_word_count[47:32]};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `PTX_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// Start pulses last exactly one clock.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_start_pulse <= 1'b0;
			read_start_pulse <= 1'b0;
		end else begin
			write_start_pulse <= start_cmd && !wr_data[`PTX_CTRL_DIR_BIT] &&
				(end_count_limit != 48'h0);
			read_start_pulse <= start_cmd && wr_data[`PTX_CTRL_DIR_BIT];
		end
	end

	assign advance = write_strobe_reg || inbound_read_strobe;
	assign last_word = advance && (transfer_word_count + 48'h1 == end_count_limit);
	assign block_end = advance && (word_idx == `PTX_LAST_WORD_IDX);
	assign next_block_address = block_address + 48'h1;
	// Transfer state; leaving the write state and dropping the strobe share one edge.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ptx_pkg::PTX_ST_IDLE;
		end else begin
			case (state)
				ptx_pkg::PTX_ST_IDLE: begin
					if (write_start_pulse) begin
						state <= ptx_pkg::PTX_ST_WRITE;
					end else if (read_start_pulse) begin
						state <= ptx_pkg::PTX_ST_READ;
					end
				end
				ptx_pkg::PTX_ST_WRITE: begin
					if (write_strobe_reg && last_word) begin
						state <= ptx_pkg::PTX_ST_IDLE;
					end
				end
				ptx_pkg::PTX_ST_READ: begin
					if (last_word) begin
						state <= ptx_pkg::PTX_ST_IDLE;
					end
				end
				default: begin
					state <= ptx_pkg::PTX_ST_IDLE;
				end
			endcase
		end
	end

	assign write_active_flag = (state == ptx_pkg::PTX_ST_WRITE);
	assign next_write_strobe = (state == ptx_pkg::PTX_ST_WRITE) &&
		!outbound_almost_full_flag && !(write_strobe_reg && last_word);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_strobe_reg <= 1'b0;
		end else begin
			write_strobe_reg <= next_write_strobe;
		end
	end

	assign outbound_write_strobe = write_strobe_reg;
	assign inbound_read_strobe = cfg.dir_read && !inbound_empty_flag;

	// Word, block and pattern counters, loaded by either start pulse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transfer_word_count <= 48'h0;
			word_idx <= 4'h0;
			block_address <= `PTX_ADDR_RST;
			inc_count <= 52'h0;
		end else if (write_start_pulse || read_start_pulse) begin
			transfer_word_count <= 48'h0;
			word_idx <= 4'h0;
			block_address <= start_address;
			inc_count <= {start_address[44:0], 7'h00};
		end else if (advance) begin
			transfer_word_count <= transfer_word_count + 48'h1;
			word_idx <= word_idx + 4'h1;
			inc_count <= inc_count + `PTX_DW_PER_WORD;
			if (block_end) begin
				block_address <= next_block_address;
			end
		end
	end

	logic lfsr_load;
	logic [47:0] seed_address;
	assign lfsr_load = write_start_pulse || read_start_pulse || block_end;
	assign seed_address = block_end ? next_block_address : start_address;

	ptx_lfsr_half lfsr_lo (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(lfsr_load),
		.adv(advance),
		.seed(seed_of(seed_address, 1'b0)),
		.words(lfsr_word[127:0])
	);

	ptx_lfsr_half lfsr_hi (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(lfsr_load),
		.adv(advance),
		.seed(seed_of(seed_address, 1'b1)),
		.words(lfsr_word[255:128])
	);

	// Builds the current 256-bit word from the selected source.
	always_comb begin
		pattern_word = 256'h0;
		for (int k = 0; k < 8; k++) begin
			logic [31:0] inc_dw;
			inc_dw = inc_count[31:0] + 32'(k);
			case (cfg.patt)
				ptx_pkg::PTX_PATT_ONE: pattern_word[k*32 +: 32] = 32'hffff_ffff;
				ptx_pkg::PTX_PATT_INC: pattern_word[k*32 +: 32] = inc_dw;
				ptx_pkg::PTX_PATT_DEC: pattern_word[k*32 +: 32] = ~inc_dw;
				ptx_pkg::PTX_PATT_LFSR: pattern_word[k*32 +: 32] = lfsr_word[k*32 +: 32];
				default: pattern_word[k*32 +: 32] = 32'h0000_0000;
			endcase
		end
		if (word_idx == 4'h0 && (cfg.patt == ptx_pkg::PTX_PATT_INC ||
				cfg.patt == ptx_pkg::PTX_PATT_DEC || cfg.patt == ptx_pkg::PTX_PATT_LFSR)) begin
			pattern_word[63:0] = {16'h0000, block_address};
		end
	end

	assign outbound_data = pattern_word;

	// Sticky fail flag, cleared by a new start.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_flag <= 1'b0;
		end else if (inbound_read_strobe && cfg.verify && inbound_data != pattern_word) begin
			fail_flag <= 1'b1;
		end else if (write_start_pulse || read_start_pulse) begin
			fail_flag <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== verif/ptx_engine_checker.sv
// Concurrent checks on the ports of the pattern test engine.
// Assumes one clock, aclk, and a synchronous active-low reset, aresetn.
`timescale 1ns/1ps
`default_nettype none
module ptx_engine_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic outbound_almost_full_flag,
	input wire logic outbound_write_strobe,
	input wire logic inbound_empty_flag,
	input wire logic inbound_read_strobe,
	input wire logic write_active_flag,
	input wire logic fail_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_last_word;
		write_active_flag && outbound_write_strobe ##1 !write_active_flag;
	endsequence
	sequence s_ready_to_send;
		write_active_flag && !outbound_almost_full_flag ##1 write_active_flag;
	endsequence
	a_strobe_needs_active: assert property (outbound_write_strobe |-> write_active_flag)
		else $error("Write strobe outside a write.");
	a_full_pauses: assert property (outbound_almost_full_flag |=> !outbound_write_strobe)
		else $error("Write strobe while almost full.");
	a_strobe_resumes: assert property (s_ready_to_send |-> outbound_write_strobe)
		else $error("Write strobe missing.");
	a_stop_together: assert property (s_last_word |-> !outbound_write_strobe)
		else $error("Strobe outlives write active.");
	a_active_after_start: assert property ($rose(write_active_flag) |-> $past(s_axi_bvalid))
		else $error("Write active without start.");
	a_read_needs_data: assert property (inbound_read_strobe |-> !inbound_empty_flag)
		else $error("Read strobe while empty.");
	a_fail_needs_read: assert property ($rose(fail_flag) |-> $past(inbound_read_strobe))
		else $error("Fail raised without a read.");
	a_fail_sticky: assert property ($fell(fail_flag) |->
		$past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("Fail cleared without a start.");
endmodule
bind ptx_engine ptx_engine_checker chk_u (.aclk, .aresetn, .s_axi_bvalid,
	.outbound_almost_full_flag, .outbound_write_strobe, .inbound_empty_flag,
	.inbound_read_strobe, .write_active_flag, .fail_flag);
`default_nettype wire

// ===== verif/ptx_buffer_model.sv
// Behavioural outbound and inbound buffers: keeps written words and replays them.
// Assumes the engine's clock and show-ahead reads of the inbound side.
`timescale 1ns/1ps
`default_nettype none
module ptx_buffer_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic replay,
	input wire logic clr,
	input wire logic corrupt,
	input wire logic outbound_write_strobe,
	input wire logic [255:0] outbound_data,
	output logic outbound_almost_full_flag,
	output logic inbound_empty_flag,
	input wire logic inbound_read_strobe,
	output logic [255:0] inbound_data
);
	logic [255:0] store [$];
	int ridx = 0;
	logic nxt_empty;
	initial begin
		inbound_empty_flag = 1'b1;
		inbound_data = '0;
		outbound_almost_full_flag = 1'b0;
	end
	// Runs on the clock shared with the engine.
	always @(posedge aclk) begin
		if (!aresetn || clr) begin
			store.delete();
		end else if (outbound_write_strobe) begin
			store.push_back(outbound_data);
		end
		if (!replay) begin
			ridx = 0;
		end else if (inbound_read_strobe) begin
			ridx = ridx + 1;
		end
		nxt_empty = !replay || ($urandom % 4 == 0) || ridx >= store.size();
		inbound_empty_flag <= nxt_empty;
		inbound_data <= nxt_empty ? ~inbound_data : store[ridx] ^ 256'(corrupt && ridx == 3);
		outbound_almost_full_flag <= aresetn && stall && ($urandom % 3 == 0);
	end
endmodule
`default_nettype wire

// ===== verif/test_fifo_test_pattern_engine.sv
// Self-checking bench: patterned write tests, then read-back tests through the model.
// Assumes the engine's registers are reached over AXI4-Lite from this bench.
`timescale 1ns/1ps
`default_nettype none
`include "ptx_map.svh"
module test_fifo_test_pattern_engine;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [`PTX_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic outbound_almost_full_flag, outbound_write_strobe, inbound_empty_flag;
	logic inbound_read_strobe, write_active_flag, fail_flag;
	logic [255:0] outbound_data, inbound_data;
	logic stall = 1'b0, replay = 1'b0, clr = 1'b0, corrupt = 1'b0;
	logic [2:0] cur_patt = 3'h0;
	logic [47:0] cur_addr = '0;
	int fail_count = 0, compares = 0, wn = 0, wbase = 0, n_end = 0;
	always #12.5 aclk = ~aclk;
	ptx_engine dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .outbound_almost_full_flag,
		.outbound_write_strobe, .outbound_data, .inbound_empty_flag, .inbound_read_strobe,
		.inbound_data, .write_active_flag, .fail_flag);
	ptx_buffer_model bm_u (.aclk, .aresetn, .stall, .replay, .clr, .corrupt,
		.outbound_write_strobe, .outbound_data, .outbound_almost_full_flag,
		.inbound_empty_flag, .inbound_read_strobe, .inbound_data);
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [255:0] got, input logic [255:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic timed_out();
		check(1'b0, 1'b1);
		give_verdict();
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				br = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		if (i == 100) timed_out();
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			d = s_axi_rdata;
			r = s_axi_rresp;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 100) timed_out();
	endtask
	task automatic run_test(input logic [31:0] ctrl, input logic play);
		int i;
		axi_write(`PTX_OFS_CTRL, ctrl);
		replay <= play;
		for (i = 0; i < 400; i++) begin
			axi_read(`PTX_OFS_STATUS, rd, rr);
			if (!rd[`PTX_STAT_BUSY_BIT]) break;
		end
		if (i == 400) timed_out();
		replay <= 1'b0;
		@(posedge aclk);
	endtask
	function automatic logic [255:0] exp_word(input logic [2:0] p, input logic [47:0] a,
		input int n);
		logic [255:0] w;
		logic [51:0] c;
		logic [47:0] b;
		logic [31:0] s;
		c = {a[44:0], 7'h0} + 52'(8 * n);
		b = a + 48'(n / 16);
		for (int k = 0; k < 8; k++) w[32 * k +: 32] = c[31:0] + 32'(k);
		if (p == ptx_pkg::PTX_PATT_DEC) w = ~w;
		// Each half restarts from its block seed and steps four states per word.
		if (p == ptx_pkg::PTX_PATT_LFSR) begin
			for (int h = 0; h < 2; h++) begin
				s = h ? {~b[15:0], b[15:0]} : {b[31:16], ~b[31:16]};
				repeat (4 * (n % 16)) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
				for (int j = 0; j < 4; j++) begin
					w[128 * h + 32 * j +: 32] = s;
					s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
				end
			end
		end
		if (n % 16 == 0) w[63:0] = {16'h0, b};
		if (p == ptx_pkg::PTX_PATT_ZERO) w = '0;
		if (p == ptx_pkg::PTX_PATT_ONE) w = '1;
		return w;
	endfunction
	always @(posedge aclk) begin
		if (outbound_write_strobe === 1'b1) begin
			check(outbound_data, exp_word(cur_patt, cur_addr, wn - wbase));
			wn++;
		end
	end
	initial begin
		void'($urandom(32'h03ee));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({write_active_flag, fail_flag, outbound_write_strobe}, 3'h0);
		axi_read(8'h40, rd, rr);
		check({rr, rd}, {`PTX_RESP_SLVERR, 32'h0});
		axi_write(8'h40, 32'h0);
		check(br, `PTX_RESP_SLVERR);
		axi_write(`PTX_OFS_END_LO, 32'h0);
		check(br, `PTX_RESP_OKAY);
		axi_write(`PTX_OFS_CTRL, 32'h1);
		repeat (3) @(posedge aclk);
		check(write_active_flag, 1'b0);
		for (int p = 0; p < 5; p++) begin
			n_end = 17 + $urandom % 24;
			cur_patt = 3'(p);
			cur_addr = {16'h0, $urandom};
			axi_write(`PTX_OFS_END_LO, n_end);
			axi_write(`PTX_OFS_ADDR_LO, cur_addr[31:0]);
			clr <= 1'b1;
			stall <= 1'b1;
			@(posedge aclk);
			clr <= 1'b0;
			wbase = wn;
			run_test({25'h0, cur_patt, 4'h1}, 1'b0);
			stall <= 1'b0;
			check(wn - wbase, n_end);
			axi_read(`PTX_OFS_COUNT_LO, rd, rr);
			check(rd, n_end);
			run_test({25'h0, cur_patt, 4'h7}, 1'b1);
			check(fail_flag, 1'b0);
			axi_read(`PTX_OFS_COUNT_LO, rd, rr);
			check(rd, n_end);
		end
		corrupt <= 1'b1;
		run_test(32'h43, 1'b1);
		check(fail_flag, 1'b0);
		run_test(32'h47, 1'b1);
		check(fail_flag, 1'b1);
		corrupt <= 1'b0;
		run_test(32'h47, 1'b1);
		check(fail_flag, 1'b0);
		axi_read(`PTX_OFS_STATUS, rd, rr);
		check(rd[`PTX_STAT_FAIL_BIT], 1'b0);
		s_axi_wstrb <= 4'h1;
		axi_write(`PTX_OFS_ADDR_HI, 32'habcd_1234);
		s_axi_wstrb <= 4'hf;
		axi_read(`PTX_OFS_ADDR_HI, rd, rr);
		check(rd, 32'h0000_0034);
		give_verdict();
	end
endmodule
`default_nettype wire
